// ==== common/sdt_pkg.sv ====
// Purpose: Shared constants for the sensor domain timer block
// Assumes: Single 20 MHz system clock
// Notes:   Encodings for timer 2 sources and synchroniser bit positions
package sdt_pkg;

  // Widths
  localparam int unsigned SDT_CNT_W    = 16;
  localparam int unsigned SDT_PRE_W    = 15;
  localparam int unsigned SDT_EXP_W    = 4;
  localparam int unsigned SDT_NUM_CH   = 4;
  localparam int unsigned SDT_NUM_SYNC = 9;

  // Reset values
  localparam logic [15:0] SDT_CNT_RST  = 16'h0000;
  localparam logic [14:0] SDT_PRE_RST  = 15'h0000;

  // Third timer source select
  localparam logic [1:0]  SDT_SRC_FAST = 2'h0;
  localparam logic [1:0]  SDT_SRC_MID  = 2'h1;
  localparam logic [1:0]  SDT_SRC_SLOW = 2'h2;
  localparam logic [1:0]  SDT_SRC_NONE = 2'h3;

  // Synchroniser bit positions
  localparam int unsigned SDT_SY_T0    = 0;
  localparam int unsigned SDT_SY_T1    = 1;
  localparam int unsigned SDT_SY_FAST  = 2;
  localparam int unsigned SDT_SY_MID   = 3;
  localparam int unsigned SDT_SY_SLOW  = 4;
  localparam int unsigned SDT_SY_CAP   = 5;

endpackage

// ==== design/sdt_basic_timer.sv ====
// Purpose: 16-bit timer with power-of-two prescaler, one-shot or periodic
// Assumes: tick_edge_i is a one-cycle pulse already synchronised
// Notes:   Instantiated twice by the sensor timer top
`timescale 1ns/1ps
`default_nettype none
module sdt_basic_timer
  import sdt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // Control
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        periodic_i,
  input  wire logic        use_tick_i,
  input  wire logic [3:0]  presc_exp_i,
  input  wire logic [15:0] target_i,
  input  wire logic        tick_edge_i,
  // Status
  output logic [15:0]      count_o,
  output logic             running_o,
  output logic             done_o
);

  logic [14:0] presc;
  logic [14:0] presc_last;
  logic        incr;
  logic        adv;

  // Increment source: every clock or every tick edge
  assign incr       = running_o & (use_tick_i ? tick_edge_i : 1'b1);
  // Prescaler divides by 2^N
  assign presc_last = SDT_PRE_W'((32'h1 << presc_exp_i) - 32'h1);
  assign adv        = incr & (presc >= presc_last);

  // Prescaler counter
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presc <= SDT_PRE_RST;
    end else if (start_i || adv) begin
      presc <= SDT_PRE_RST;
    end else if (incr) begin
      presc <= presc + 15'h0001;
    end
  end

  // 16-bit counter with one-shot or periodic restart
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o   <= SDT_CNT_RST;
      running_o <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count_o   <= SDT_CNT_RST;
        running_o <= 1'b1;
      end else if (stop_i) begin
        running_o <= 1'b0;
      end else if (adv) begin
        if (count_o == target_i) begin
          done_o  <= 1'b1;
          count_o <= SDT_CNT_RST;            // Restart from zero
          if (!periodic_i) begin
            running_o <= 1'b0;               // One-shot halts
          end
        end else begin
          count_o <= count_o + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== design/sdt_sensor_timers.sv ====
// Purpose: Three sensor domain timers with events and waveform outputs
// Assumes: 20 MHz sys_clk_i; source and capture pins are asynchronous
// Notes:   Source edges faster than sys_clk_i/2 cannot all be seen
`timescale 1ns/1ps
`default_nettype none
module sdt_sensor_timers
  import sdt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // Timer 0 control
  input  wire logic        t0_start_i,
  input  wire logic        t0_stop_i,
  input  wire logic        t0_periodic_i,
  input  wire logic        t0_use_tick_i,
  input  wire logic [3:0]  t0_presc_exp_i,
  input  wire logic [15:0] t0_target_i,
  input  wire logic        t0_tick_pin_i,
  // Timer 1 control
  input  wire logic        t1_start_i,
  input  wire logic        t1_stop_i,
  input  wire logic        t1_periodic_i,
  input  wire logic        t1_use_tick_i,
  input  wire logic [3:0]  t1_presc_exp_i,
  input  wire logic [15:0] t1_target_i,
  input  wire logic        t1_tick_pin_i,
  // Timer 2 control and sources
  input  wire logic        t2_start_i,
  input  wire logic        t2_stop_i,
  input  wire logic        t2_periodic_i,
  input  wire logic [1:0]  t2_src_sel_i,
  input  wire logic [15:0] t2_target_i,
  input  wire logic        src_fast_i,
  input  wire logic        src_mid_i,
  input  wire logic        src_slow_i,
  // Timer 2 channel control
  input  wire logic [3:0]  ch_arm_i,
  input  wire logic [3:0]  ch_capture_i,
  input  wire logic [3:0]  ch_periodic_i,
  input  wire logic [3:0]  ch_pwm_i,
  input  wire logic [63:0] ch_compare_i,
  input  wire logic [3:0]  ch_cap_pin_i,
  input  wire logic [3:0]  ch_adc_en_i,
  // Timer 0 and 1 status
  output logic [15:0]      t0_count_o,
  output logic             t0_running_o,
  output logic             t0_done_o,
  output logic [15:0]      t1_count_o,
  output logic             t1_running_o,
  output logic             t1_done_o,
  // Timer 2 status and events
  output logic [15:0]      t2_count_o,
  output logic             t2_running_o,
  output logic             t2_wrap_o,
  output logic [3:0]       ch_armed_o,
  output logic [63:0]      ch_captured_o,
  output logic [3:0]       proc_evt_o,
  output logic             adc_trig_o,
  output logic [3:0]       wave_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection

  logic [8:0] sync_a;
  logic [8:0] sync_b;
  logic [8:0] sync_c;
  logic [8:0] pin_vec;
  logic [8:0] rise;

  assign pin_vec = {ch_cap_pin_i, src_slow_i, src_mid_i, src_fast_i,
                    t1_tick_pin_i, t0_tick_pin_i};

  // Two flops per pin, then a third for edge detection
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
      sync_c <= 9'h000;
    end else begin
      sync_a <= pin_vec;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Tick source edges count on either polarity
  logic [8:0] any_edge;
  assign any_edge = sync_b ^ sync_c;
  assign rise     = sync_b & ~sync_c;

  ////////////////////////////////////////////////////////////////////////////
  // Timers 0 and 1

  sdt_basic_timer u_timer0 (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .start_i     (t0_start_i),
    .stop_i      (t0_stop_i),
    .periodic_i  (t0_periodic_i),
    .use_tick_i  (t0_use_tick_i),
    .presc_exp_i (t0_presc_exp_i),
    .target_i    (t0_target_i),
    .tick_edge_i (any_edge[SDT_SY_T0]),
    .count_o     (t0_count_o),
    .running_o   (t0_running_o),
    .done_o      (t0_done_o)
  );

  sdt_basic_timer u_timer1 (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .start_i     (t1_start_i),
    .stop_i      (t1_stop_i),
    .periodic_i  (t1_periodic_i),
    .use_tick_i  (t1_use_tick_i),
    .presc_exp_i (t1_presc_exp_i),
    .target_i    (t1_target_i),
    .tick_edge_i (any_edge[SDT_SY_T1]),
    .count_o     (t1_count_o),
    .running_o   (t1_running_o),
    .done_o      (t1_done_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timer 2 counter

  logic t2_adv;
  logic t2_match_end;

  // Source select; no dependency on processor state
  always_comb begin
    case (t2_src_sel_i)
      SDT_SRC_FAST: t2_adv = rise[SDT_SY_FAST];
      SDT_SRC_MID:  t2_adv = rise[SDT_SY_MID];
      SDT_SRC_SLOW: t2_adv = rise[SDT_SY_SLOW];
      default:      t2_adv = 1'b0;
    endcase
    t2_adv = t2_adv & t2_running_o;
  end

  assign t2_match_end = t2_adv && (t2_count_o == t2_target_i);

  // 16-bit counter, one-shot or periodic
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t2_count_o   <= SDT_CNT_RST;
      t2_running_o <= 1'b0;
      t2_wrap_o    <= 1'b0;
    end else begin
      t2_wrap_o <= t2_match_end;
      if (t2_start_i) begin
        t2_count_o   <= SDT_CNT_RST;
        t2_running_o <= 1'b1;
      end else if (t2_stop_i) begin
        t2_running_o <= 1'b0;
      end else if (t2_match_end) begin
        t2_count_o <= SDT_CNT_RST;
        if (!t2_periodic_i) begin
          t2_running_o <= 1'b0;
        end
      end else if (t2_adv) begin
        t2_count_o <= t2_count_o + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer 2 channels

  logic [3:0] ch_hit;

  genvar c;
  generate
    for (c = 0; c < SDT_NUM_CH; c++) begin : g_ch
      logic [15:0] cmp;
      logic        cap_edge;
      assign cmp      = ch_compare_i[c*16 +: 16];
      assign cap_edge = rise[SDT_SY_CAP + c];
      // Capture on input edge, compare on counter match
      assign ch_hit[c] = ch_armed_o[c] &&
                         (ch_capture_i[c] ? cap_edge
                                          : (t2_adv && (t2_count_o == cmp)));

      // Arming: one-shot disarms after one hit; arm request wins
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ch_armed_o[c] <= 1'b0;
        end else if (ch_arm_i[c] || t2_start_i) begin
          ch_armed_o[c] <= 1'b1;
        end else if (ch_hit[c] && !ch_periodic_i[c]) begin
          ch_armed_o[c] <= 1'b0;
        end
      end

      // Captured counter value
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ch_captured_o[c*16 +: 16] <= SDT_CNT_RST;
        end else if (ch_hit[c] && ch_capture_i[c]) begin
          ch_captured_o[c*16 +: 16] <= t2_count_o;
        end
      end

      // Waveform output: PWM sets on wrap, clears on match; else toggles
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          wave_o[c] <= 1'b0;
        end else if (!ch_capture_i[c]) begin
          if (ch_pwm_i[c]) begin
            if (ch_hit[c]) begin
              wave_o[c] <= 1'b0;
            end else if (t2_match_end || t2_start_i) begin
              wave_o[c] <= 1'b1;
            end
          end else if (ch_hit[c]) begin
            wave_o[c] <= ~wave_o[c];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs

  // Channel hits toward the processor, enabled ones toward the ADC
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      proc_evt_o <= 4'h0;
      adc_trig_o <= 1'b0;
    end else begin
      proc_evt_o <= ch_hit;
      adc_trig_o <= |(ch_hit & ch_adc_en_i);
    end
  end

endmodule
`default_nettype wire

// ==== verification/sdt_timers_monitor.sv ====
// Purpose: Port checker for the sensor timers
// Assumes: One clock domain, reset active low
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ps
`default_nettype none
module sdt_timers_monitor
  import sdt_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  // Watched inputs
  input wire logic        t0_start_i,
  input wire logic        t0_periodic_i,
  input wire logic [3:0]  ch_capture_i,
  input wire logic [3:0]  ch_adc_en_i,
  // Watched outputs
  input wire logic [15:0] t0_count_o,
  input wire logic        t0_running_o,
  input wire logic        t0_done_o,
  input wire logic [15:0] t2_count_o,
  input wire logic [3:0]  proc_evt_o,
  input wire logic        adc_trig_o,
  input wire logic [63:0] ch_captured_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Counters restart at zero and step by one
  property p_t0_zero;
    t0_done_o |-> t0_count_o == 16'h0000;
  endproperty
  a_t0_zero: assert property (p_t0_zero) else $error("t0 match not at zero");
  property p_t0_step;
    t0_count_o == $past(t0_count_o) || t0_count_o == $past(t0_count_o) + 16'h0001
      || t0_count_o == 16'h0000;
  endproperty
  a_t0_step: assert property (p_t0_step) else $error("t0 count jumped");
  property p_t2_step;
    t2_count_o == $past(t2_count_o) || t2_count_o == $past(t2_count_o) + 16'h0001
      || t2_count_o == 16'h0000;
  endproperty
  a_t2_step: assert property (p_t2_step) else $error("t2 count jumped");
  property p_t0_once;
    t0_done_o && !$past(t0_periodic_i) && !$past(t0_start_i) |-> !t0_running_o;
  endproperty
  a_t0_once: assert property (p_t0_once) else $error("t0 one-shot ran on");
  property p_t0_ran;
    t0_done_o |-> $past(t0_running_o);
  endproperty
  a_t0_ran: assert property (p_t0_ran) else $error("t0 match while idle");
  // Channel events
  property p_adc;
    adc_trig_o |-> (proc_evt_o & $past(ch_adc_en_i)) != 4'h0;
  endproperty
  a_adc: assert property (p_adc) else $error("adc trigger without enabled hit");
  property p_evt_pulse;
    proc_evt_o[3] |=> !proc_evt_o[3];
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than one cycle");
  property p_cap;
    proc_evt_o[0] && $past(ch_capture_i[0]) |-> ch_captured_o[15:0] == $past(t2_count_o);
  endproperty
  a_cap: assert property (p_cap) else $error("captured value wrong");
endmodule
bind sdt_sensor_timers sdt_timers_monitor i_mon (
  .sys_clk_i     (sys_clk_i),
  .resetn_i      (resetn_i),
  .t0_start_i    (t0_start_i),
  .t0_periodic_i (t0_periodic_i),
  .ch_capture_i  (ch_capture_i),
  .ch_adc_en_i   (ch_adc_en_i),
  .t0_count_o    (t0_count_o),
  .t0_running_o  (t0_running_o),
  .t0_done_o     (t0_done_o),
  .t2_count_o    (t2_count_o),
  .proc_evt_o    (proc_evt_o),
  .adc_trig_o    (adc_trig_o),
  .ch_captured_o (ch_captured_o)
);
`default_nettype wire

// ==== verification/sdt_evt_sink.sv ====
// Purpose: Processor and ADC trigger inputs
// Assumes: Events are one-cycle pulses
// Notes:   Counts pulses since the last clear
`timescale 1ns/1ps
`default_nettype none
module sdt_evt_sink (
  // Clock, clear and events
  input  wire logic       sys_clk_i,
  input  wire logic       clr_i,
  input  wire logic [3:0] evt_i,
  input  wire logic       adc_i,
  // Counts
  output logic [31:0]     evt_cnt_o,
  output logic [7:0]      adc_cnt_o
);
  // Take each pulse as the receivers would
  always_ff @(posedge sys_clk_i) begin
    for (int c = 0; c < 4; c++) begin
      evt_cnt_o[8*c+:8] <= clr_i ? 8'h00 : evt_cnt_o[8*c+:8] + {7'h00, evt_i[c]};
    end
    adc_cnt_o <= clr_i ? 8'h00 : adc_cnt_o + {7'h00, adc_i};
  end
endmodule
`default_nettype wire

// ==== verification/sensor_domain_timers_test.sv ====
// Purpose: Self-checking bench for the sensor timers
// Assumes: 20 MHz clock, reset held three cycles
// Notes:   Timers 0 and 1 follow a cycle model; timer 2 runs on each source
`timescale 1ns/1ps
`default_nettype none
module sensor_domain_timers_test;
  logic        sys_clk_i = 1'b0, resetn_i = 1'b0, t2_start_i = 1'b0, clr = 1'b0;
  logic        t2_stop_i = 1'b0, t2_periodic_i = 1'b1, t2_running_o, t2_wrap_o, adc_trig_o;
  logic [1:0]  st = '0, sp = '0, per = '0, ut = '0, tk = '0, run, dn, t2_src_sel_i = '0;
  logic [3:0]  pe [2] = '{4'h0, 4'h0};
  logic [15:0] tg [2] = '{16'h0, 16'h0}, cnt [2], t2_count_o, t2_target_i = 16'h0009;
  logic [2:0]  src = '0;
  logic [3:0]  ch_arm_i = '0, ch_capture_i = 4'h1, ch_periodic_i = 4'h6, ch_pwm_i = 4'h4;
  logic [3:0]  ch_adc_en_i = 4'h4, ch_cap_pin_i = '0, ch_armed_o, proc_evt_o, wave_o;
  logic [63:0] ch_compare_i = 64'h0007_0005_0003_0000, ch_captured_o;
  logic [31:0] ecnt;
  logic [7:0]  acnt;
  int          err_count = 0, samples_checked = 0, seed = 34866, cyc = 0, r, wraps = 0;
  int          m_cnt [2], m_pre [2], m_run [2], m_dn [2];

  sdt_sensor_timers i_dut (
    .sys_clk_i, .resetn_i, .t0_start_i(st[0]), .t0_stop_i(sp[0]), .t0_periodic_i(per[0]),
    .t0_use_tick_i(ut[0]), .t0_presc_exp_i(pe[0]), .t0_target_i(tg[0]), .t0_tick_pin_i(tk[0]),
    .t1_start_i(st[1]), .t1_stop_i(sp[1]), .t1_periodic_i(per[1]), .t1_use_tick_i(ut[1]),
    .t1_presc_exp_i(pe[1]), .t1_target_i(tg[1]), .t1_tick_pin_i(tk[1]), .t2_start_i,
    .t2_stop_i, .t2_periodic_i, .t2_src_sel_i, .t2_target_i, .src_fast_i(src[0]),
    .src_mid_i(src[1]), .src_slow_i(src[2]), .ch_arm_i, .ch_capture_i, .ch_periodic_i,
    .ch_pwm_i, .ch_compare_i, .ch_cap_pin_i, .ch_adc_en_i, .t0_count_o(cnt[0]),
    .t0_running_o(run[0]), .t0_done_o(dn[0]), .t1_count_o(cnt[1]), .t1_running_o(run[1]),
    .t1_done_o(dn[1]), .t2_count_o, .t2_running_o, .t2_wrap_o, .ch_armed_o, .ch_captured_o,
    .proc_evt_o, .adc_trig_o, .wave_o);
  sdt_evt_sink i_sink (.sys_clk_i, .clr_i(clr), .evt_i(proc_evt_o), .adc_i(adc_trig_o),
    .evt_cnt_o(ecnt), .adc_cnt_o(acnt));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cut a hung run short
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  // Count timer 2 wrap pulses since the last start
  always @(negedge sys_clk_i) begin
    if (t2_start_i) wraps = 0;
    else if (t2_wrap_o === 1'b1) wraps++;
  end

  // Cycle model of timers 0 and 1 counting the clock
  always @(posedge sys_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      m_dn[i] = 0;
      if (!resetn_i || st[i]) begin
        m_cnt[i] = 0;
        m_pre[i] = 0;
        m_run[i] = resetn_i;
      end else if (sp[i]) m_run[i] = 0;
      else if (m_run[i] != 0 && m_pre[i] < (1 << pe[i]) - 1) m_pre[i]++;
      else if (m_run[i] != 0) begin
        m_pre[i] = 0;
        m_dn[i] = m_cnt[i] == tg[i];
        m_run[i] = m_dn[i] != 0 ? per[i] : 1;
        m_cnt[i] = m_dn[i] != 0 ? 0 : m_cnt[i] + 1;
      end
    end
  end

  // Compare the model each cycle while the timers count the clock
  always @(negedge sys_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (resetn_i && !ut[i]) begin
        chk("count", 16'(m_cnt[i]), cnt[i]);
        chk("running", 16'(m_run[i]), 16'(run[i]));
        chk("done", 16'(m_dn[i]), 16'(dn[i]));
      end
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    // Random starts, stops and settings
    repeat (1500) begin
      @(posedge sys_clk_i);
      for (int i = 0; i < 2; i++) begin
        r = $random(seed);
        st[i] <= r[5:0] == 6'h00;
        sp[i] <= r[20:14] == 7'h00;
        if (r[5:0] == 6'h00) begin
          pe[i] <= {2'h0, r[7:6]};
          tg[i] <= {13'h0000, r[10:8]};
          per[i] <= r[11];
        end
      end
    end
    $display("random timer test done");
    // Both edges of the tick pins advance
    @(posedge sys_clk_i);
    st <= 2'h3;
    sp <= 2'h0;
    ut <= 2'h3;
    pe <= '{4'h0, 4'h0};
    tg <= '{16'h00ff, 16'h00ff};
    @(posedge sys_clk_i);
    st <= 2'h0;
    repeat (6) begin
      repeat (4) @(posedge sys_clk_i);
      tk <= ~tk;
    end
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk("tick count", 16'h0006, cnt[0]);
    chk("tick count", 16'h0006, cnt[1]);
    $display("tick test done");
    // Timer 2 on each source, other sources toggling at half the rate
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk_i);
      t2_src_sel_i <= s[1:0];
      t2_start_i <= 1'b1;
      clr <= 1'b1;
      @(posedge sys_clk_i);
      t2_start_i <= 1'b0;
      clr <= 1'b0;
      for (int k = 0; k < 80; k++) begin
        repeat (2) @(posedge sys_clk_i);
        src <= src ^ (k[0] ? 3'h7 : 3'h1 << s);
        ch_cap_pin_i <= {3'h0, k > 30 && k < 36};
      end
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk("t2 count", 16'h0000, t2_count_o);
      chk("t2 running", 16'h0001, 16'(t2_running_o));
      chk("armed", 16'h0006, 16'(ch_armed_o));
      chk("waves", s[0] ? 16'h0004 : 16'h000c, 16'(wave_o));
      for (int c = 0; c < 4; c++) begin
        chk("events", (c == 1 || c == 2) ? 16'h0004 : 16'h0001, 16'(ecnt[8*c+:8]));
      end
      chk("adc triggers", 16'h0004, 16'(acnt));
      chk("wraps", 16'h0004, 16'(wraps));
      chk("captured", 16'h0006, ch_captured_o[15:0]);
      $display("timer 2 source test done");
    end
    // No source selected: timer 2 holds; arm pulses re-arm; stop halts it
    @(posedge sys_clk_i);
    t2_src_sel_i <= 2'h3;
    ch_arm_i <= 4'h9;
    @(posedge sys_clk_i);
    ch_arm_i <= 4'h0;
    repeat (8) begin
      repeat (2) @(posedge sys_clk_i);
      src <= ~src;
    end
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk("t2 held", 16'h0000, t2_count_o);
    chk("rearmed", 16'h000f, 16'(ch_armed_o));
    @(posedge sys_clk_i);
    t2_stop_i <= 1'b1;
    @(posedge sys_clk_i);
    t2_stop_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("t2 stopped", 16'h0000, 16'(t2_running_o));
    $display("source select test done");
    results();
  end
endmodule
`default_nettype wire
